// *** src/upc_defs.vh ***
`ifndef UPC_DEFS_VH
`define UPC_DEFS_VH
// timing figures in ns
`define UPC_CLK_NS 40
`define UPC_SETUP_NS 2000
`define UPC_HOLD_NS 2000
`define UPC_FAST_PW_NS 100000
`define UPC_INTER_PW_NS 1000000
`define UPC_OVER_PW_NS 2000000
`define UPC_DV_NS 250
`define UPC_ACC_NS 150
// cycle counts: least times round up
`define UPC_CYC_UP(ns) (((ns) + `UPC_CLK_NS - 1) / `UPC_CLK_NS)
`define UPC_FAST_MAX_PULSES 8'h19
`define UPC_INTER_MAX_PULSES 8'h19
`define UPC_ERASED_BYTE 8'hff
// command codes
`define UPC_CMD_READ 3'h0
`define UPC_CMD_PROG_FAST 3'h1
`define UPC_CMD_PROG_INTER 3'h2
`define UPC_CMD_IDENT 3'h3
`define UPC_CMD_VERIFY 3'h4
// supply select codes
`define UPC_VCC_NOM 2'h0
`define UPC_VCC_INTER 2'h1
`define UPC_VCC_FAST 2'h2
`endif

// *** src/upc_ctrl.v ***
`timescale 1ns/1ps
`include "upc_defs.vh"
module upc_ctrl #(
  parameter AW = 16,
  parameter SETUP_CYC = `UPC_CYC_UP(`UPC_SETUP_NS),
  parameter HOLD_CYC = `UPC_CYC_UP(`UPC_HOLD_NS),
  parameter FAST_PW_CYC = `UPC_CYC_UP(`UPC_FAST_PW_NS),
  parameter INTER_PW_CYC = `UPC_CYC_UP(`UPC_INTER_PW_NS),
  parameter OVER_PW_CYC = `UPC_CYC_UP(`UPC_OVER_PW_NS),
  parameter DV_CYC = `UPC_CYC_UP(`UPC_DV_NS),
  parameter ACC_CYC = `UPC_CYC_UP(`UPC_ACC_NS)
) (
  input wire mclk_in,
  input wire arst_n_in,
  input wire cmd_valid_in,
  input wire [2:0] cmd_in,
  input wire [AW-1:0] cmd_addr_in,
  input wire [7:0] cmd_data_in,
  output wire cmd_ready_out,
  output reg done_out,
  output reg fail_out,
  output reg [7:0] rd_data_out,
  output reg [5:0] pulses_out,
  output reg [AW-1:0] mem_addr_out,
  output reg mem_select_n_out,
  output reg mem_gate_n_out,
  output reg prog_hv_out,
  output reg id_hv_out,
  output reg [1:0] vcc_sel_out,
  input wire [7:0] mem_dq_in,
  output reg [7:0] mem_dq_out,
  output reg mem_dq_oe_out
);
  localparam S_IDLE = 4'h0;
  localparam S_SETUP = 4'h1;
  localparam S_PULSE = 4'h2;
  localparam S_HOLD = 4'h3;
  localparam S_VSEL = 4'h4;
  localparam S_VWAIT = 4'h5;
  localparam S_RGATE = 4'h6;
  localparam S_RWAIT = 4'h7;
  localparam S_OVER = 4'h8;
  localparam S_REC = 4'h9;
  localparam CW = 21;
  reg [3:0] state;
  reg [2:0] cmd;
  reg [7:0] wdata;
  reg [CW-1:0] cnt;
  reg [7:0] dq_s1;
  reg [7:0] dq_s2;
  reg [7:0] dq_s3;
  reg [7:0] dq_agreed;
  wire [7:0] max_pulses;
  assign cmd_ready_out = (state == S_IDLE);
  assign max_pulses = (cmd == `UPC_CMD_PROG_FAST) ? `UPC_FAST_MAX_PULSES : `UPC_INTER_MAX_PULSES;
  function [CW-1:0] cyc;
    input integer n;
    begin
      cyc = n[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction
  function is_prog;
    input [2:0] c;
    begin
      is_prog = (c == `UPC_CMD_PROG_FAST) || (c == `UPC_CMD_PROG_INTER);
    end
  endfunction
  // three-stage input sync; bytes count once last two stages agree
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
      dq_agreed <= 8'h00;
    end else begin
      dq_s1 <= mem_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      // a byte still settling keeps the last agreed value
      if (dq_s2 == dq_s3) dq_agreed <= dq_s3;
    end
  end
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= S_IDLE;
      cmd <= 3'h0;
      wdata <= 8'h00;
      cnt <= {CW{1'b0}};
      done_out <= 1'b0;
      fail_out <= 1'b0;
      rd_data_out <= 8'h00;
      pulses_out <= 6'h00;
      mem_addr_out <= {AW{1'b0}};
      mem_select_n_out <= 1'b1;
      mem_gate_n_out <= 1'b1;
      prog_hv_out <= 1'b0;
      id_hv_out <= 1'b0;
      vcc_sel_out <= `UPC_VCC_NOM;
      mem_dq_out <= 8'h00;
      mem_dq_oe_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (cnt != {CW{1'b0}}) cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
      case (state)
        S_IDLE: begin
          mem_select_n_out <= 1'b1;
          mem_gate_n_out <= 1'b1;
          if (cmd_valid_in) begin
            cmd <= cmd_in;
            wdata <= cmd_data_in;
            pulses_out <= 6'h00;
            fail_out <= 1'b0;
            cnt <= cyc(SETUP_CYC);
            if (cmd_in == `UPC_CMD_IDENT) begin
              // other address lines low, byte select from request
              mem_addr_out <= {{(AW-1){1'b0}}, cmd_addr_in[0]};
              id_hv_out <= 1'b1;
              state <= S_VSEL;
            end else if (is_prog(cmd_in)) begin
              mem_addr_out <= cmd_addr_in;
              mem_dq_out <= cmd_data_in;
              mem_dq_oe_out <= 1'b1;
              prog_hv_out <= 1'b1;
              vcc_sel_out <= (cmd_in == `UPC_CMD_PROG_FAST) ? `UPC_VCC_FAST : `UPC_VCC_INTER;
              state <= S_SETUP;
            end else begin
              mem_addr_out <= cmd_addr_in;
              vcc_sel_out <= `UPC_VCC_NOM;
              state <= S_VSEL;
            end
          end
        end
        // address, data, supplies settle before the select pulse
        S_SETUP: if (cnt == {CW{1'b0}}) begin
          mem_select_n_out <= 1'b0;
          pulses_out <= pulses_out + 6'h01;
          cnt <= cyc(cmd == `UPC_CMD_PROG_FAST ? FAST_PW_CYC : INTER_PW_CYC);
          state <= S_PULSE;
        end
        S_PULSE: if (cnt == {CW{1'b0}}) begin
          mem_select_n_out <= 1'b1;
          cnt <= cyc(HOLD_CYC);
          state <= S_HOLD;
        end
        // data hold, then release bus and drop programming voltage
        S_HOLD: if (cnt == {CW{1'b0}}) begin
          mem_dq_oe_out <= 1'b0;
          prog_hv_out <= 1'b0;
          cnt <= cyc(HOLD_CYC);
          state <= S_VSEL;
        end
        // gate low must follow the recovery time after high voltage drops
        S_VSEL: if (cnt == {CW{1'b0}}) begin
          mem_select_n_out <= 1'b0;
          mem_gate_n_out <= 1'b0;
          cnt <= cyc((cmd == `UPC_CMD_READ) ? ACC_CYC : DV_CYC);
          state <= S_VWAIT;
        end
        // extra four cycles cover the synchroniser and its agreement stage
        S_VWAIT: if (cnt == {CW{1'b0}}) begin
          cnt <= cyc(4);
          state <= S_RWAIT;
        end
        S_RWAIT: if (cnt == {CW{1'b0}}) begin
          rd_data_out <= dq_agreed;
          mem_select_n_out <= 1'b1;
          mem_gate_n_out <= 1'b1;
          state <= S_RGATE;
        end
        S_RGATE: begin
          if (is_prog(cmd)) begin
            if (rd_data_out == wdata) begin
              if (cmd == `UPC_CMD_PROG_INTER) begin
                // one overprogram pulse per location
                mem_dq_oe_out <= 1'b1;
                prog_hv_out <= 1'b1;
                cnt <= cyc(SETUP_CYC);
                state <= S_OVER;
              end else begin
                state <= S_REC;
              end
            end else if ({2'b00, pulses_out} >= max_pulses) begin
              fail_out <= 1'b1;
              state <= S_REC;
            end else begin
              mem_dq_oe_out <= 1'b1;
              prog_hv_out <= 1'b1;
              cnt <= cyc(SETUP_CYC);
              state <= S_SETUP;
            end
          end else begin
            if (cmd == `UPC_CMD_IDENT) fail_out <= ~(^rd_data_out);
            state <= S_REC;
          end
        end
        S_OVER: if (cnt == {CW{1'b0}}) begin
          if (mem_select_n_out) begin
            mem_select_n_out <= 1'b0;
            cnt <= cyc(OVER_PW_CYC);
          end else begin
            mem_select_n_out <= 1'b1;
            cnt <= cyc(HOLD_CYC);
            state <= S_REC;
          end
        end
        S_REC: if (cnt == {CW{1'b0}}) begin
          mem_dq_oe_out <= 1'b0;
          prog_hv_out <= 1'b0;
          id_hv_out <= 1'b0;
          vcc_sel_out <= `UPC_VCC_NOM;
          done_out <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // upc_ctrl

// *** verif/upc_eprom_model.sv ***
`timescale 1ns/1ps
module upc_eprom_model #(
  parameter [7:0] MAKER = 8'h8f, // arbitrary value, odd parity
  parameter [7:0] PART = 8'h13 // arbitrary value, odd parity
) (
  input wire [15:0] addr_in,
  input wire sel_n_in,
  input wire gate_n_in,
  input wire hv_in,
  input wire id_in,
  input wire [7:0] d_in,
  input wire stuck_in,
  output wire drv_out,
  output wire [7:0] q_out
);
  logic [7:0] mem [0:65535];
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  assign drv_out = !sel_n_in && !gate_n_in && !hv_in;
  assign q_out = id_in ? (addr_in[0] ? PART : MAKER) : mem[addr_in];
  // cells only clear; stuck_in mimics a cell that will not take
  always @(posedge sel_n_in)
    if (hv_in && !stuck_in) mem[addr_in] <= mem[addr_in] & d_in;
endmodule // upc_eprom_model

// *** verif/upc_ctrl_properties.sv ***
`timescale 1ns/1ps
`include "upc_defs.vh"
module upc_ctrl_props #(
  parameter AW = 16,
  parameter FAST_PW_CYC = 4
) (
  input wire mclk_in,
  input wire arst_n_in,
  input wire [5:0] pulses_out,
  input wire [AW-1:0] mem_addr_out,
  input wire mem_select_n_out,
  input wire mem_gate_n_out,
  input wire prog_hv_out,
  input wire id_hv_out,
  input wire [1:0] vcc_sel_out,
  input wire [7:0] mem_dq_out,
  input wire mem_dq_oe_out
);
  logic [15:0] low_cnt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  always @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in) low_cnt <= 16'h0;
    else low_cnt <= mem_select_n_out ? 16'h0 : low_cnt + 16'h1;
  a_drive_in_prog: assert property (mem_dq_oe_out && !mem_select_n_out |-> prog_hv_out)
    else $error("data driven outside programming");
  a_no_contention: assert property (mem_dq_oe_out |-> mem_gate_n_out || prog_hv_out)
    else $error("data driven while gate low");
  a_pulse_setup: assert property ($fell(mem_select_n_out) && prog_hv_out |-> mem_dq_oe_out && $stable(mem_dq_out)
    && $stable(mem_addr_out)) else $error("pulse without stable setup");
  a_addr_held: assert property (!mem_select_n_out ##1 !mem_select_n_out |-> $stable(mem_addr_out))
    else $error("address moved while selected");
  a_id_lines_low: assert property (id_hv_out |-> mem_addr_out[AW-1:1] == '0)
    else $error("id mode with upper address set");
  a_raised_supply: assert property (prog_hv_out && !mem_select_n_out |-> vcc_sel_out != `UPC_VCC_NOM)
    else $error("program pulse at nominal supply");
  a_pulse_cap: assert property (pulses_out <= 6'h19)
    else $error("pulse count above limit");
  a_fast_width: assert property ($rose(mem_select_n_out) && $past(prog_hv_out) && $past(vcc_sel_out) == `UPC_VCC_FAST
    |-> low_cnt == FAST_PW_CYC) else $error("fast pulse width wrong");
  c_fast_pulse: cover property ($fell(mem_select_n_out) && prog_hv_out);
  c_ident: cover property (id_hv_out && !mem_select_n_out);
  c_limit: cover property (pulses_out == 6'h19);
endmodule // upc_ctrl_props
bind upc_ctrl upc_ctrl_props #(.AW(AW), .FAST_PW_CYC(FAST_PW_CYC)) i_upc_ctrl_props (.mclk_in, .arst_n_in,
  .pulses_out, .mem_addr_out, .mem_select_n_out, .mem_gate_n_out, .prog_hv_out, .id_hv_out, .vcc_sel_out,
  .mem_dq_out, .mem_dq_oe_out);

// *** verif/upc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`include "upc_defs.vh"
module upc_ctrl_tb_top;
  localparam [7:0] MAKER = 8'h8f; // arbitrary, odd parity
  localparam [7:0] PART = 8'h13; // arbitrary, odd parity
  logic mclk_in = 1'b0, arst_n_in = 1'b0, cmd_valid_in = 1'b0, stuck = 1'b0;
  logic [2:0] cmd_in = 3'h0;
  logic [15:0] cmd_addr_in = 16'h0;
  logic [7:0] cmd_data_in = 8'h0, prev = 8'h0;
  wire cmd_ready_out, done_out, fail_out, mem_select_n_out, mem_gate_n_out, prog_hv_out, id_hv_out, mem_dq_oe_out, drv;
  wire [7:0] rd_data_out, mem_dq_out, dev_q, mem_dq_in;
  wire [5:0] pulses_out;
  wire [15:0] mem_addr_out;
  wire [1:0] vcc_sel_out;
  int n_mismatch = 0, cmp_count = 0;
  logic [7:0] shadow [int];
  always #20 mclk_in = ~mclk_in;
  // a released bus keeps changing so a stale byte cannot pass
  assign mem_dq_in = mem_dq_oe_out ? mem_dq_out : drv ? dev_q : ~prev;
  always @(posedge mclk_in) prev <= mem_dq_in;
  upc_ctrl #(.SETUP_CYC(2), .HOLD_CYC(2), .FAST_PW_CYC(4), .INTER_PW_CYC(5), .OVER_PW_CYC(6)) i_upc_ctrl (.mclk_in,
    .arst_n_in, .cmd_valid_in, .cmd_in, .cmd_addr_in, .cmd_data_in, .cmd_ready_out, .done_out, .fail_out, .rd_data_out,
    .pulses_out, .mem_addr_out, .mem_select_n_out, .mem_gate_n_out, .prog_hv_out, .id_hv_out, .vcc_sel_out, .mem_dq_in,
    .mem_dq_out, .mem_dq_oe_out);
  upc_eprom_model #(.MAKER(MAKER), .PART(PART)) i_upc_eprom_model (.addr_in(mem_addr_out), .sel_n_in(mem_select_n_out),
    .gate_n_in(mem_gate_n_out), .hv_in(prog_hv_out), .id_in(id_hv_out), .d_in(mem_dq_in), .stuck_in(stuck),
    .drv_out(drv), .q_out(dev_q));
  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic op(logic [2:0] c, logic [15:0] a, logic [7:0] d);
    int t = 0;
    @(negedge mclk_in);
    cmd_in <= c;
    cmd_addr_in <= a;
    cmd_data_in <= d;
    cmd_valid_in <= 1'b1;
    while (cmd_ready_out !== 1'b1) @(negedge mclk_in);
    @(negedge mclk_in);
    cmd_valid_in <= 1'b0;
    while (done_out !== 1'b1 && t < 5000) begin
      @(negedge mclk_in);
      t++;
    end
    if (t >= 5000) n_mismatch++;
  endtask
  function automatic logic [7:0] expv(logic [15:0] a);
    return shadow.exists(a) ? shadow[a] : `UPC_ERASED_BYTE;
  endfunction
  task automatic prog(logic [2:0] c, logic [15:0] a, logic [7:0] d);
    logic [7:0] nw;
    nw = stuck ? expv(a) : expv(a) & d;
    op(c, a, d);
    shadow[a] = nw;
    check("fail", {7'h0, fail_out}, {7'h0, nw !== d});
    if (c == `UPC_CMD_PROG_FAST) check("pulses", {2'h0, pulses_out}, nw === d ? 8'h01 : 8'h19);
    op(`UPC_CMD_READ, a, 8'h0);
    check("read", rd_data_out, nw);
    op(`UPC_CMD_VERIFY, a, 8'h0);
    check("verify", rd_data_out, nw);
  endtask
  initial begin
    logic [2:0] c;
    void'($urandom(30));
    repeat (5) @(negedge mclk_in);
    arst_n_in <= 1'b1;
    op(`UPC_CMD_IDENT, 16'h0, 8'h0);
    check("maker", rd_data_out, MAKER);
    op(`UPC_CMD_IDENT, 16'h1, 8'h0);
    check("part", rd_data_out, PART);
    check("id fail", {7'h0, fail_out}, 8'h0);
    prog(`UPC_CMD_PROG_FAST, 16'hffff, 8'h00);
    stuck = 1'b1;
    prog(`UPC_CMD_PROG_FAST, 16'h0001, 8'h5a);
    prog(`UPC_CMD_PROG_INTER, 16'h0002, 8'ha5);
    stuck = 1'b0;
    repeat (12) begin
      c = $urandom_range(1) ? `UPC_CMD_PROG_FAST : `UPC_CMD_PROG_INTER;
      prog(c, 16'($urandom_range(7)), 8'($urandom));
    end
    finish_test;
  end
  initial begin
    #2000000;
    n_mismatch++;
    finish_test;
  end
endmodule // upc_ctrl_tb_top
